// [testbench/efl_dec_model.sv]
`timescale 1ns/10ps
`default_nettype none
//----------------------------------------------------------------------
// Behavioural ECC decoder that feeds error reports to the log.
//----------------------------------------------------------------------
module efl_dec_model (
   // Clock
   input wire logic clk,
   // Error reports
   output logic ce_valid,
   output logic ue_valid,
   output logic [127:0] err_data,
   output logic [15:0] err_check_bits,
   output logic [55:0] err_address,
   output logic [7:0] err_beat_mask
);
   // Starts idle with no report pending.
   initial begin
      ce_valid = 1'b0;
      ue_valid = 1'b0;
      err_data = '0;
      err_check_bits = '0;
      err_address = '0;
      err_beat_mask = '0;
   end

   // Sends one report as a one-cycle pulse, then scrambles the payload.
   task automatic report(input logic ue, input logic [127:0] d, input logic [15:0] c,
                         input logic [55:0] a, input logic [7:0] m);
      @(posedge clk);
      ce_valid <= ~ue;
      ue_valid <= ue;
      err_data <= d;
      err_check_bits <= c;
      err_address <= a;
      err_beat_mask <= m;
      @(posedge clk);
      ce_valid <= 1'b0;
      ue_valid <= 1'b0;
      err_data <= ~d;
      err_check_bits <= ~c;
      err_address <= ~a;
      err_beat_mask <= ~m;
   endtask : report
endmodule : efl_dec_model
`default_nettype wire

// [testbench/efl_first_error_log_tb.sv]
`timescale 1ns/10ps
`default_nettype none
module efl_first_error_log_tb;
   // Payloads of the reports sent by the decoder model.
   localparam logic [127:0] D1 = 128'h0123_4567_89AB_CDEF_FEDC_BA98_7654_3210;
   localparam logic [127:0] D2 = 128'hA5A5_1111_C3C3_2222_5A5A_3333_3C3C_4444;
   localparam logic [15:0] C1 = 16'hBEEF;
   localparam logic [15:0] C2 = 16'h1234;
   localparam logic [55:0] A1 = 56'hC0_FFEE_1234_5678;
   localparam logic [55:0] A2 = 56'h11_2233_4455_6677;
   logic clk = 1'b0, rst = 1'b1;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata_w, prdata_n, rd_w, rd_n;
   logic pready_w, pready_n, pslverr_w, pslverr_n, irq_w, irq_n, slv_err;
   logic [1:0] slv_n;
   logic ce_valid, ue_valid;
   logic [127:0] err_data;
   logic [15:0] err_check_bits;
   logic [55:0] err_address;
   logic [7:0] err_beat_mask;
   int n_mismatch = 0, checked = 0, cycles = 0;

   // Clock of 100 ns period.
   always #50 clk = ~clk;

   // Wide instance and narrow instance share the bus and the decoder.
   efl_first_error_log #(.DQ_WIDTH(144)) dut_u (.clk(clk), .rst(rst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata_w), .pready(pready_w), .pslverr(pslverr_w), .ce_valid(ce_valid),
      .ue_valid(ue_valid), .err_data(err_data), .err_check_bits(err_check_bits),
      .err_address(err_address), .err_beat_mask(err_beat_mask), .irq(irq_w));
   efl_first_error_log #(.DQ_WIDTH(72)) dut_n (.clk(clk), .rst(rst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata_n), .pready(pready_n), .pslverr(pslverr_n), .ce_valid(ce_valid),
      .ue_valid(ue_valid), .err_data(err_data), .err_check_bits(err_check_bits),
      .err_address(err_address), .err_beat_mask(err_beat_mask), .irq(irq_n));
   efl_dec_model dec_u (.clk(clk), .ce_valid(ce_valid), .ue_valid(ue_valid),
      .err_data(err_data), .err_check_bits(err_check_bits), .err_address(err_address),
      .err_beat_mask(err_beat_mask));

   // Prints the counts and the verdict, then stops.
   task automatic wrap_up();
      $display("comparisons %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : wrap_up

   // Cuts a hung run short.
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         n_mismatch++;
         wrap_up();
      end
   end

   // Compares one value with its expectation.
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   // One APB transfer: setup, then access until pready is sampled high.
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'b1;
      // Only the bench timeout ends a wait that never sees ready.
      do begin
         @(posedge clk);
      end while (pready_w !== 1'b1);
      rd_w = prdata_w;
      rd_n = prdata_n;
      slv_err = pslverr_w;
      slv_n = {pready_n, pslverr_n};
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   // Reads one register of both instances and compares.
   task automatic rd(input logic [7:0] a, input logic [31:0] ew, input logic [31:0] en);
      apb(1'b0, a, 32'h0);
      check(rd_w, ew);
      check(rd_n, en);
   endtask : rd

   // Checks the interrupt of both instances once the flag change has landed.
   task automatic irq_is(input logic e);
      repeat (2) @(posedge clk);
      check({31'h0, irq_w}, {31'h0, e});
      check({31'h0, irq_n}, {31'h0, e});
   endtask : irq_is

   // Checks all logs of one class against a report's payload.
   task automatic ce_logs(input logic [127:0] d, input logic [15:0] c);
      rd(efl_pkg::OFF_CE_WORD1, d[63:32], d[63:32]);
      rd(efl_pkg::OFF_CE_WORD2, d[95:64], 32'h0);
      rd(efl_pkg::OFF_CE_WORD3, d[127:96], 32'h0);
      rd(efl_pkg::OFF_CE_CHECK, {16'h0, c}, {24'h0, c[7:0]});
   endtask : ce_logs

   task automatic ue_logs(input logic [127:0] d, input logic [55:0] a, input logic [7:0] m);
      rd(efl_pkg::OFF_UE_ADDR_LO, a[31:0], a[31:0]);
      rd(efl_pkg::OFF_UE_ADDR_HI, {m, a[55:32]}, {m, a[55:32]});
      rd(efl_pkg::OFF_UE_WORD0, d[31:0], d[31:0]);
      rd(efl_pkg::OFF_UE_WORD1, d[63:32], d[63:32]);
      rd(efl_pkg::OFF_UE_WORD2, d[95:64], 32'h0);
   endtask : ue_logs

   // Main sequence of tests.
   initial begin
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      for (int i = 0; i <= 12; i++) begin
         rd(8'(4 * i), 32'h0, 32'h0);
      end
      $display("test reset done");
      dec_u.report(1'b0, D1, C1, A1, 8'h00);
      dec_u.report(1'b0, D2, C2, A2, 8'h00);
      ce_logs(D1, C1);
      rd(efl_pkg::OFF_STATUS, 32'h2, 32'h2);
      $display("test correctable done");
      dec_u.report(1'b1, D1, C1, A1, 8'h81);
      dec_u.report(1'b1, D2, C2, A2, 8'h7E);
      ue_logs(D1, A1, 8'h81);
      rd(efl_pkg::OFF_STATUS, 32'h3, 32'h3);
      $display("test uncorrectable done");
      apb(1'b1, efl_pkg::OFF_CE_WORD1, 32'hFFFF_FFFF);
      check({31'h0, slv_err}, 32'h0);
      rd(efl_pkg::OFF_CE_WORD1, D1[63:32], D1[63:32]);
      apb(1'b0, 8'h40, 32'h0);
      check({31'h0, slv_err}, 32'h1);
      check({30'h0, slv_n}, 32'h3);
      check(rd_w, 32'h0);
      $display("test access done");
      apb(1'b1, efl_pkg::OFF_IRQ_MASK, 32'h2);
      irq_is(1'b1);
      rd(efl_pkg::OFF_IRQ_MASK, 32'h2, 32'h2);
      apb(1'b1, efl_pkg::OFF_STATUS, 32'h2);
      irq_is(1'b0);
      rd(efl_pkg::OFF_STATUS, 32'h1, 32'h1);
      dec_u.report(1'b0, D2, C2, A2, 8'h00);
      irq_is(1'b1);
      ce_logs(D2, C2);
      apb(1'b1, efl_pkg::OFF_IRQ_MASK, 32'h1);
      irq_is(1'b1);
      apb(1'b1, efl_pkg::OFF_STATUS, 32'h1);
      irq_is(1'b0);
      dec_u.report(1'b1, D2, C2, A2, 8'h7E);
      irq_is(1'b1);
      ue_logs(D2, A2, 8'h7E);
      $display("test rearm done");
      // An uncorrectable error lands in the same edge as the write that clears its flag.
      fork
         apb(1'b1, efl_pkg::OFF_STATUS, 32'h1);
         begin
            repeat (2) @(posedge clk);
            dec_u.report(1'b1, D1, C1, A1, 8'h81);
         end
      join
      rd(efl_pkg::OFF_STATUS, 32'h3, 32'h3);
      ue_logs(D1, A1, 8'h81);
      $display("test clear race done");
      wrap_up();
   end
endmodule : efl_first_error_log_tb
`default_nettype wire

// [verilog/efl_arm_slot.sv]
`timescale 1ns/10ps
`default_nettype none
//----------------------------------------------------------------------
// Sticky flag of one error class and the capture strobe it arms.
//----------------------------------------------------------------------
module efl_arm_slot (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Error event and software clear
   input wire logic err_pulse,
   input wire logic clear_req,
   // Flag and capture strobe
   output logic flag_r,
   output logic take
);
   logic flag_nxt;

   // A capture is allowed while the flag is clear, or in the very cycle it
   // is cleared, so an error that meets the clear is never lost.
   assign take = err_pulse & (~flag_r | clear_req);

   // The set wins over the clear.
   assign flag_nxt = err_pulse | (flag_r & ~clear_req); // RL17

   // Flag register, clear after reset so the logs start armed.
   always_ff @(posedge clk) begin
      if (rst) begin
         flag_r <= 1'b0; // RL16
      end else begin
         flag_r <= flag_nxt;
      end
   end
endmodule : efl_arm_slot
`default_nettype wire

// [verilog/efl_first_error_log.sv]
// Functional notes
// RL1: First correctable error latches corrected data bits 63:32.
// RL2: At 144-bit width also latch corrected data bits 95:64.
// RL3: At 144-bit width also latch corrected data bits 127:96.
// RL4: Correctable data logs freeze until the correctable flag clears.
// RL5: At 72-bit width the 8 check bits go to bits 7:0.
// RL6: At 144-bit width the 16 check bits go to bits 15:0.
// RL7: Check-bit log freezes until the correctable flag clears.
// RL8: First uncorrectable error latches failing address bits 31:0.
// RL9: Failing address bits 55:32 go to upper log bits 23:0.
// RL10: Per-beat uncorrectable mask in bits 31:24, bit 24 first beat.
// RL11: Uncorrectable address logs freeze until the uncorrectable flag clears.
// RL12: First uncorrectable error latches raw data bits 31:0.
// RL13: First uncorrectable error latches raw data bits 63:32.
// RL14: At 144-bit width also latch raw data bits 95:64.
// RL15: Uncorrectable data logs freeze until the uncorrectable flag clears.
// RL16: After reset every log is armed for the first error.
// RL17: Errors set sticky flags; writing one clears and re-arms.
// RL18: At 72-bit width the wide-only logs read as zero.
`timescale 1ns/10ps
`default_nettype none
module efl_first_error_log #(
   parameter int DQ_WIDTH = 72
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Error reports from the decoder
   input wire logic ce_valid,
   input wire logic ue_valid,
   input wire logic [127:0] err_data,
   input wire logic [15:0] err_check_bits,
   input wire logic [55:0] err_address,
   input wire logic [7:0] err_beat_mask,
   // Interrupt
   output logic irq
);
   //-------------------------------------------------------------------
   // Declarations
   //-------------------------------------------------------------------
   localparam bit WIDE = (DQ_WIDTH == efl_pkg::DQ_WIDE);

   logic ce_flag_r;
   logic ue_flag_r;
   logic ce_take;
   logic ue_take;
   logic ce_clear;
   logic ue_clear;
   logic [1:0] irq_mask_r;
   logic [31:0] ce_word1_r;
   logic [31:0] ce_word2_r;
   logic [31:0] ce_word3_r;
   logic [15:0] ce_check_r;
   logic [31:0] ue_addr_lo_r;
   logic [31:0] ue_addr_hi_r;
   logic [31:0] ue_word0_r;
   logic [31:0] ue_word1_r;
   logic [31:0] ue_word2_r;
   logic [15:0] check_in;
   logic access;
   logic done;
   logic wr_done;
   logic [31:0] rd_nxt;
   logic irq_nxt;

   //-------------------------------------------------------------------
   // Address decode
   //-------------------------------------------------------------------
   // True when the byte address names a register of the map.
   function automatic logic is_mapped(input logic [7:0] addr);
      is_mapped = (addr == efl_pkg::OFF_STATUS) || (addr == efl_pkg::OFF_IRQ_MASK)
         || (addr == efl_pkg::OFF_CE_WORD1) || (addr == efl_pkg::OFF_CE_WORD2)
         || (addr == efl_pkg::OFF_CE_WORD3) || (addr == efl_pkg::OFF_CE_CHECK)
         || (addr == efl_pkg::OFF_UE_ADDR_LO) || (addr == efl_pkg::OFF_UE_ADDR_HI)
         || (addr == efl_pkg::OFF_UE_WORD0) || (addr == efl_pkg::OFF_UE_WORD1)
         || (addr == efl_pkg::OFF_UE_WORD2);
   endfunction : is_mapped

   //-------------------------------------------------------------------
   // APB handshake
   //-------------------------------------------------------------------
   // Every access phase takes two cycles: pready rises on the second.
   assign access = psel & penable;
   assign done = access & pready;
   assign wr_done = done & pwrite & is_mapped(paddr);

   // Ready toggles on for one cycle during each access phase.
   always_ff @(posedge clk) begin
      if (rst) begin
         pready <= 1'b0;
      end else begin
         pready <= access & ~pready;
      end
   end

   // An unmapped address answers with an error, together with ready.
   always_ff @(posedge clk) begin
      if (rst) begin
         pslverr <= 1'b0;
      end else begin
         pslverr <= access & ~pready & ~is_mapped(paddr);
      end
   end

   //-------------------------------------------------------------------
   // Status flags and re-arming
   //-------------------------------------------------------------------
   // Writing a one to a status bit clears that flag.
   assign ce_clear = wr_done && (paddr == efl_pkg::OFF_STATUS) && pwdata[efl_pkg::BIT_CE]; // RL17
   assign ue_clear = wr_done && (paddr == efl_pkg::OFF_STATUS) && pwdata[efl_pkg::BIT_UE]; // RL17

   // Correctable class: flag and capture strobe.
   efl_arm_slot u_ce_slot (
      .clk(clk),
      .rst(rst),
      .err_pulse(ce_valid),
      .clear_req(ce_clear),
      .flag_r(ce_flag_r),
      .take(ce_take)
   );

   // Uncorrectable class: flag and capture strobe.
   efl_arm_slot u_ue_slot (
      .clk(clk),
      .rst(rst),
      .err_pulse(ue_valid),
      .clear_req(ue_clear),
      .flag_r(ue_flag_r),
      .take(ue_take)
   );

   // Interrupt mask, written by software.
   always_ff @(posedge clk) begin
      if (rst) begin
         irq_mask_r <= efl_pkg::MASK_RESET;
      end else if (wr_done && (paddr == efl_pkg::OFF_IRQ_MASK)) begin
         irq_mask_r <= pwdata[1:0];
      end
   end

   // Interrupt is high while an unmasked flag is set.
   assign irq_nxt = |({ce_flag_r, ue_flag_r} & irq_mask_r);

   always_ff @(posedge clk) begin
      if (rst) begin
         irq <= 1'b0;
      end else begin
         irq <= irq_nxt;
      end
   end

   //-------------------------------------------------------------------
   // Correctable error logs
   //-------------------------------------------------------------------
   // A narrow memory has only eight check bits; the upper byte stays zero.
   assign check_in = WIDE ? err_check_bits : {8'h00, err_check_bits[7:0]}; // RL5 RL6

   // Corrected data word 1 is captured only on an armed strobe.
   always_ff @(posedge clk) begin
      if (rst) begin
         ce_word1_r <= efl_pkg::LOG_RESET;
      end else if (ce_take) begin // RL4
         ce_word1_r <= err_data[63:32]; // RL1
      end
   end

   // Upper corrected words exist only on the wide memory.
   always_ff @(posedge clk) begin
      if (rst) begin
         ce_word2_r <= efl_pkg::LOG_RESET;
         ce_word3_r <= efl_pkg::LOG_RESET;
      end else if (ce_take && WIDE) begin // RL4 RL18
         ce_word2_r <= err_data[95:64]; // RL2
         ce_word3_r <= err_data[127:96]; // RL3
      end
   end

   // Check-bit log, frozen while the correctable flag is set.
   always_ff @(posedge clk) begin
      if (rst) begin
         ce_check_r <= efl_pkg::LOG_RESET[15:0];
      end else if (ce_take) begin // RL7
         ce_check_r <= check_in; // RL5 RL6
      end
   end

   //-------------------------------------------------------------------
   // Uncorrectable error logs
   //-------------------------------------------------------------------
   // Address logs: low word, then high field with the per-beat mask on top.
   always_ff @(posedge clk) begin
      if (rst) begin
         ue_addr_lo_r <= efl_pkg::LOG_RESET;
         ue_addr_hi_r <= efl_pkg::LOG_RESET;
      end else if (ue_take) begin // RL11
         ue_addr_lo_r <= err_address[31:0]; // RL8
         ue_addr_hi_r <= {err_beat_mask,
            err_address[efl_pkg::ADDR_HI_MSB:efl_pkg::ADDR_HI_LSB]}; // RL9 RL10
      end
   end

   // Raw data words 0 and 1.
   always_ff @(posedge clk) begin
      if (rst) begin
         ue_word0_r <= efl_pkg::LOG_RESET;
         ue_word1_r <= efl_pkg::LOG_RESET;
      end else if (ue_take) begin // RL15
         ue_word0_r <= err_data[31:0]; // RL12
         ue_word1_r <= err_data[63:32]; // RL13
      end
   end

   // Raw data word 2 exists only on the wide memory.
   always_ff @(posedge clk) begin
      if (rst) begin
         ue_word2_r <= efl_pkg::LOG_RESET;
      end else if (ue_take && WIDE) begin // RL15 RL18
         ue_word2_r <= err_data[95:64]; // RL14
      end
   end

   //-------------------------------------------------------------------
   // Read path
   //-------------------------------------------------------------------
   // Selects the addressed register; reserved bits and unmapped reads give zero.
   always_comb begin
      rd_nxt = 32'h0000_0000;
      unique case (paddr)
         efl_pkg::OFF_STATUS: rd_nxt = {30'h0000_0000, ce_flag_r, ue_flag_r};
         efl_pkg::OFF_IRQ_MASK: rd_nxt = {30'h0000_0000, irq_mask_r};
         efl_pkg::OFF_CE_WORD1: rd_nxt = ce_word1_r;
         efl_pkg::OFF_CE_WORD2: rd_nxt = ce_word2_r; // RL18
         efl_pkg::OFF_CE_WORD3: rd_nxt = ce_word3_r; // RL18
         efl_pkg::OFF_CE_CHECK: rd_nxt = {16'h0000, ce_check_r};
         efl_pkg::OFF_UE_ADDR_LO: rd_nxt = ue_addr_lo_r;
         efl_pkg::OFF_UE_ADDR_HI: rd_nxt = ue_addr_hi_r;
         efl_pkg::OFF_UE_WORD0: rd_nxt = ue_word0_r;
         efl_pkg::OFF_UE_WORD1: rd_nxt = ue_word1_r;
         efl_pkg::OFF_UE_WORD2: rd_nxt = ue_word2_r; // RL18
         default: rd_nxt = 32'h0000_0000;
      endcase
   end

   // Read data is loaded with ready and held until the next read access.
   always_ff @(posedge clk) begin
      if (rst) begin
         prdata <= 32'h0000_0000;
      end else if (access && !pready && !pwrite) begin
         prdata <= rd_nxt;
      end
   end

   //-------------------------------------------------------------------
   // Assertions
   //-------------------------------------------------------------------
   default clocking cb @(posedge clk);
   endclocking

   default disable iff (rst);

   // A completed write of a one into the correctable status bit.
   sequence ce_clear_write_s;
      psel && penable && pready && pwrite && (paddr == efl_pkg::OFF_STATUS)
         && pwdata[efl_pkg::BIT_CE];
   endsequence

   // A cycle with the correctable flag already set and no clear, with or without an error.
   sequence ce_blocked_s;
      ce_flag_r && !ce_clear;
   endsequence

   // A cycle with the uncorrectable flag already set and no clear, with or without an error.
   sequence ue_blocked_s;
      ue_flag_r && !ue_clear;
   endsequence

   ce_word1_capture_a: assert property (ce_valid && !ce_flag_r |=> // RL1
      ce_word1_r == $past(err_data[63:32]))
      else $error("Correctable word 1 not captured.");

   ce_upper_words_a: assert property (ce_take |=> // RL2 RL3 RL18
      (WIDE ? (ce_word2_r == $past(err_data[95:64]))
         && (ce_word3_r == $past(err_data[127:96]))
         : (ce_word2_r == 32'h0000_0000) && (ce_word3_r == 32'h0000_0000)))
      else $error("Correctable upper words wrong for the memory width.");

   ce_data_hold_a: assert property (ce_blocked_s |=> $stable(ce_word1_r) // RL4
      && $stable(ce_word2_r) && $stable(ce_word3_r))
      else $error("Correctable data log changed while frozen.");

   ce_check_capture_a: assert property (ce_take |=> // RL5 RL6
      ce_check_r == (WIDE ? $past(err_check_bits) : {8'h00, $past(err_check_bits[7:0])}))
      else $error("Correctable check bits not captured.");

   ce_check_hold_a: assert property (ce_blocked_s |=> $stable(ce_check_r)) // RL7
      else $error("Check-bit log changed while frozen.");

   ue_addr_capture_a: assert property (ue_valid && !ue_flag_r |=> // RL8 RL9 RL10
      (ue_addr_lo_r == $past(err_address[31:0]))
      && (ue_addr_hi_r[23:0] == $past(err_address[55:32]))
      && (ue_addr_hi_r[31:24] == $past(err_beat_mask)))
      else $error("Uncorrectable address log wrong.");

   ue_logs_hold_a: assert property (ue_blocked_s |=> $stable(ue_addr_lo_r) // RL11 RL15
      && $stable(ue_addr_hi_r) && $stable(ue_word0_r) && $stable(ue_word1_r)
      && $stable(ue_word2_r))
      else $error("Uncorrectable log changed while frozen.");

   ue_data_capture_a: assert property (ue_take |=> // RL12 RL13 RL14
      (ue_word0_r == $past(err_data[31:0])) && (ue_word1_r == $past(err_data[63:32]))
      && (ue_word2_r == (WIDE ? $past(err_data[95:64]) : 32'h0000_0000)))
      else $error("Uncorrectable data log wrong.");

   armed_after_reset_a: assert property (disable iff (1'b0) rst |=> // RL16
      !ce_flag_r && !ue_flag_r)
      else $error("Logs not armed after reset.");

   ce_clear_rearm_a: assert property (ce_clear_write_s ##0 !ce_valid |=> // RL17
      !ce_flag_r)
      else $error("Correctable flag not cleared by a written one.");

   flag_set_wins_a: assert property (ce_valid || ue_valid |=> // RL17
      (ce_flag_r || !$past(ce_valid)) && (ue_flag_r || !$past(ue_valid)))
      else $error("Error event lost against a clear.");

   irq_level_a: assert property (##1 irq == $past(|({ce_flag_r, ue_flag_r} & irq_mask_r)))
      else $error("Interrupt does not follow the unmasked flags.");

   apb_answer_a: assert property (psel && penable && !pready |=> pready ##1 !pready)
      else $error("Access phase not answered on its second cycle.");
endmodule : efl_first_error_log
`default_nettype wire

// [verilog/efl_pkg.sv]
//----------------------------------------------------------------------
// Register map, field layout and reset values of the error log.
//----------------------------------------------------------------------
package efl_pkg;
   // Register byte offsets on the APB port.
   localparam logic [7:0] OFF_STATUS = 8'h00;
   localparam logic [7:0] OFF_IRQ_MASK = 8'h04;
   localparam logic [7:0] OFF_CE_WORD1 = 8'h10;
   localparam logic [7:0] OFF_CE_WORD2 = 8'h14;
   localparam logic [7:0] OFF_CE_WORD3 = 8'h18;
   localparam logic [7:0] OFF_CE_CHECK = 8'h1C;
   localparam logic [7:0] OFF_UE_ADDR_LO = 8'h20;
   localparam logic [7:0] OFF_UE_ADDR_HI = 8'h24;
   localparam logic [7:0] OFF_UE_WORD0 = 8'h28;
   localparam logic [7:0] OFF_UE_WORD1 = 8'h2C;
   localparam logic [7:0] OFF_UE_WORD2 = 8'h30;

   // Bit positions in the status and mask registers.
   localparam int BIT_UE = 0;
   localparam int BIT_CE = 1;

   // Address bits that feed the upper address log, and the mask field position in it.
   localparam int ADDR_HI_LSB = 32;
   localparam int ADDR_HI_MSB = 55;
   localparam int BEAT_MASK_LSB = 24;

   // Memory widths that the log knows about.
   localparam int DQ_NARROW = 72;
   localparam int DQ_WIDE = 144;

   // Reset values.
   localparam logic [31:0] LOG_RESET = 32'h0000_0000;
   localparam logic [1:0] FLAGS_RESET = 2'h0;
   localparam logic [1:0] MASK_RESET = 2'h0;
endpackage : efl_pkg
